// File: nsx_regs.vh
// Purpose: Constants for the nibble swap / xor / direction load datapath
// Assumes: 8-bit data, 5-bit file address, 100 MHz core clock
// Notes: Included by both design files
// Functional notes
// - Nibble exchange puts file bits 3..0 into result bits 7..4 and 7..4 into 3..0, flags untouched.
// - Nibble exchange writes the working register when the destination bit is 0, the file register when 1.
// - Direction load copies the working register into the direction register named by the operand (6 or 7 valid), no flags.
// - File xor combines working register and file register 0 to 31, changing only the zero flag.
// - File xor stores into the working register when the destination bit is 0, the file register when 1.
// - Immediate xor combines working register with an 8-bit literal, writes the working register, zero flag only.
`ifndef NSX_REGS_VH
`define NSX_REGS_VH
`define NSX_OP_NONE 3'h0
`define NSX_OP_SWAP 3'h1
`define NSX_OP_DIRLD 3'h2
`define NSX_OP_XORF 3'h3
`define NSX_OP_XORK 3'h4
`define NSX_DEST_W 1'h0
`define NSX_DEST_F 1'h1
`define NSX_DIR_A 3'h6
`define NSX_DIR_B 3'h7
`define NSX_W_RST 8'h00
`define NSX_DIR_RST 8'hff
`endif

// File: nsx_alu.v
// Purpose: Combinational result and zero flag for the four operations
// Assumes: Operation code from the package header
// Notes: Pure logic, no state
`timescale 1ns/1ns
`include "nsx_regs.vh"
module nsx_alu (
   input wire [2:0] op,
   input wire [7:0] w_val,
   input wire [7:0] f_val,
   input wire [7:0] lit,
   output reg [7:0] result,
   output wire zero
);
   always @* begin
      case (op)
         `NSX_OP_SWAP: result = {f_val[3:0], f_val[7:4]};
         `NSX_OP_XORF: result = w_val ^ f_val;
         `NSX_OP_XORK: result = w_val ^ lit;
         default: result = w_val;
      endcase
   end
   assign zero = (result == 8'h00);
endmodule

// File: nsx_exec.v
// Purpose: Execute stage for nibble exchange, xor and direction load
// Assumes: Decoder gives one-cycle exec_valid with operands; file data already read
// Notes: File write-back leaves as a one-cycle request with address and data
`timescale 1ns/1ns
`include "nsx_regs.vh"
module nsx_exec (
   input wire clk,
   input wire rst,
   input wire exec_valid,
   input wire [2:0] exec_op,
   input wire [4:0] file_addr,
   input wire dest_sel,
   input wire [7:0] file_rdata,
   input wire [7:0] literal,
   input wire zero_in,
   output reg [7:0] w_r,
   output reg zero_r,
   output reg zero_we_r,
   output reg file_we_r,
   output reg [4:0] file_waddr_r,
   output reg [7:0] file_wdata_r,
   output reg [7:0] dir_a_r,
   output reg [7:0] dir_b_r,
   output reg bad_dir_r
);
   // ==========================================
   // Decode helpers
   function op_hit;
      input valid;
      input [2:0] code;
      input [2:0] want;
      begin
         op_hit = valid && (code == want);
      end
   endfunction

   // Upper operand bits must be clear
   function dir_hit;
      input [4:0] addr;
      input [2:0] want;
      begin
         dir_hit = (addr[4:3] == 2'h0) && (addr[2:0] == want);
      end
   endfunction

   // ==========================================
   // Result path
   wire [7:0] result;
   wire zero;

   nsx_alu u_alu (
      .op(exec_op),
      .w_val(w_r),
      .f_val(file_rdata),
      .lit(literal),
      .result(result),
      .zero(zero)
   );

   // ==========================================
   // Operation decode
   wire is_swap;
   wire is_xorf;
   wire is_xork;
   wire is_dir;
   wire is_xor;
   wire keep_zero;
   wire dest_file;
   wire to_file;
   wire to_w;
   wire dir_a_sel;
   wire dir_b_sel;
   wire dir_bad;

   assign is_swap = op_hit(exec_valid, exec_op, `NSX_OP_SWAP);
   assign is_xorf = op_hit(exec_valid, exec_op, `NSX_OP_XORF);
   assign is_xork = op_hit(exec_valid, exec_op, `NSX_OP_XORK);
   assign is_dir = op_hit(exec_valid, exec_op, `NSX_OP_DIRLD);
   assign is_xor = is_xorf || is_xork;
   // Swap and direction load leave the flag alone
   assign keep_zero = is_swap || is_dir;
   assign dest_file = (dest_sel == `NSX_DEST_F);
   assign to_file = (is_swap || is_xorf) && dest_file;
   assign to_w = ((is_swap || is_xorf) && !dest_file) || is_xork;
   assign dir_a_sel = is_dir && dir_hit(file_addr, `NSX_DIR_A);
   assign dir_b_sel = is_dir && dir_hit(file_addr, `NSX_DIR_B);
   assign dir_bad = is_dir && !dir_a_sel && !dir_b_sel;

   // ==========================================
   // Next-state values
   reg [7:0] w_nxt;
   reg zero_nxt;
   reg zero_we_nxt;
   reg file_we_nxt;
   reg [4:0] file_waddr_nxt;
   reg [7:0] file_wdata_nxt;
   reg [7:0] dir_a_nxt;
   reg [7:0] dir_b_nxt;
   reg bad_dir_nxt;

   // Working register
   always @* begin
      w_nxt = w_r;
      if (to_w) begin
         w_nxt = result;
      end
   end

   // Zero flag from xor forms; other cycles follow zero_in, except swap and direction load
   always @* begin
      zero_nxt = zero_r;
      zero_we_nxt = 1'b0;
      if (is_xor) begin
         zero_nxt = zero;
         zero_we_nxt = 1'b1;
      end else if (!keep_zero) begin
         zero_nxt = zero_in;
      end
   end

   // File write-back request
   always @* begin
      file_we_nxt = to_file;
      file_waddr_nxt = file_waddr_r;
      file_wdata_nxt = file_wdata_r;
      if (to_file) begin
         file_waddr_nxt = file_addr;
         file_wdata_nxt = result;
      end
   end

   // Direction registers
   always @* begin
      dir_a_nxt = dir_a_r;
      dir_b_nxt = dir_b_r;
      bad_dir_nxt = dir_bad;
      if (dir_a_sel) begin
         dir_a_nxt = w_r;
      end
      if (dir_b_sel) begin
         dir_b_nxt = w_r;
      end
   end

   // ==========================================
   // Registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         w_r <= `NSX_W_RST;
      end else begin
         w_r <= w_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         zero_r <= 1'b0;
      end else begin
         zero_r <= zero_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         zero_we_r <= 1'b0;
      end else begin
         zero_we_r <= zero_we_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         file_we_r <= 1'b0;
      end else begin
         file_we_r <= file_we_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         file_waddr_r <= 5'h00;
      end else begin
         file_waddr_r <= file_waddr_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         file_wdata_r <= 8'h00;
      end else begin
         file_wdata_r <= file_wdata_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_a_r <= `NSX_DIR_RST;
      end else begin
         dir_a_r <= dir_a_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_b_r <= `NSX_DIR_RST;
      end else begin
         dir_b_r <= dir_b_nxt;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bad_dir_r <= 1'b0;
      end else begin
         bad_dir_r <= bad_dir_nxt;
      end
   end
endmodule

// File: nsx_exec_sva.sv
// Purpose: Port assertions for the exec stage
// Assumes: Latency one, pulses last one cycle
// Notes: Bound to nsx_exec
`timescale 1ns/1ns
module nsx_exec_sva(input clk, rst, exec_valid, dest_sel, zero_r, zero_we_r, file_we_r,
   bad_dir_r,
   input [2:0] exec_op, input [4:0] file_addr,
   input [7:0] file_rdata, literal, w_r, file_wdata_r, dir_a_r, dir_b_r);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire [7:0] sr = {file_rdata[3:0], file_rdata[7:4]};
   wire [7:0] xr = w_r ^ file_rdata;
   wire [7:0] xl = w_r ^ literal;
   wire sw = exec_valid && exec_op == 3'h1;
   wire xf = exec_valid && exec_op == 3'h3;
   AST_SWAP_W: assert property (sw && !dest_sel |=> w_r == $past(sr) && !zero_we_r)
      else $error("swap to w wrong");
   AST_SWAP_F: assert property (sw && dest_sel |=> file_we_r && file_wdata_r == $past(sr))
      else $error("swap to file wrong");
   AST_DIR: assert property (exec_valid && exec_op == 3'h2 && file_addr == 5'h06 |=>
      dir_a_r == $past(w_r) && !zero_we_r) else $error("direction load wrong");
   AST_XORF_Z: assert property (xf |=> zero_we_r && zero_r == ($past(xr) == 8'h00))
      else $error("file xor zero wrong");
   AST_XORF_D: assert property (xf && !dest_sel |=> w_r == $past(xr) && !file_we_r)
      else $error("file xor dest wrong");
   AST_XORK: assert property (exec_valid && exec_op == 3'h4 |=> w_r == $past(xl) && zero_we_r)
      else $error("literal xor wrong");
   AST_DIR_B: assert property (exec_valid && exec_op == 3'h2 && file_addr == 5'h07 |=>
      dir_b_r == $past(w_r) && !zero_we_r) else $error("second direction load wrong");
   AST_DIR_BAD: assert property (exec_valid && exec_op == 3'h2 && file_addr != 5'h06 &&
      file_addr != 5'h07 |=> bad_dir_r && dir_a_r == $past(dir_a_r) && dir_b_r == $past(dir_b_r))
      else $error("bad direction operand wrong");
endmodule
bind nsx_exec nsx_exec_sva nsx_exec_sva_i(.*);

// File: tb.sv
// Purpose: Directed bench for the exec stage
// Assumes: Inputs driven at falling edge
// Notes: Results judged one cycle after issue
`timescale 1ns/1ns
module tb;
   reg clk = 0, rst = 1, v = 0, d = 0, zi = 0;
   reg [2:0] op = 0;
   reg [4:0] a = 0;
   reg [7:0] rd = 0, k = 0;
   wire [7:0] w, fd, da, db;
   wire [4:0] fa;
   wire z, zw, fw, bd;
   integer n_errors = 0, samples_checked = 0;
   nsx_exec nsx_exec_i(.clk(clk), .rst(rst), .exec_valid(v), .exec_op(op), .file_addr(a),
      .dest_sel(d), .file_rdata(rd), .literal(k), .zero_in(zi), .w_r(w), .zero_r(z),
      .zero_we_r(zw), .file_we_r(fw), .file_waddr_r(fa), .file_wdata_r(fd), .dir_a_r(da),
      .dir_b_r(db), .bad_dir_r(bd));
   initial forever #5 clk = ~clk;
   task end_sim; begin
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   end endtask
   task chk(input [63:0] nm, input [14:0] e, input [14:0] s); begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
         n_errors = n_errors + 1;
         $display("wrong value %0s exp %h got %h", nm, e, s);
      end
   end endtask
   task run(input [2:0] o, input [4:0] ad, input dd, input [7:0] r, input [7:0] kk); begin
      @(negedge clk);
      op = o; a = ad; d = dd; rd = r; k = kk; v = 1;
      @(negedge clk);
      v = 0;
   end endtask
   task t_zin; begin
      @(negedge clk) zi = 1;
      @(negedge clk) chk("zin", 15'h0001, {14'h0000, z});
      op = 3'h1; a = 5'h05; d = 1; rd = 8'h11; v = 1; zi = 0;
      @(negedge clk) v = 0;
      chk("zhold", {1'h1, 5'h05, 1'h1, 8'h11}, {fw, fa, z, fd});
   end endtask
   task t_swap; begin
      run(3'h1, 5'h05, 0, 8'h3c, 8'h00);
      chk("swapw", {7'h00, 8'hc3}, {5'h00, zw, fw, w});
      run(3'h1, 5'h09, 1, 8'ha5, 8'h00);
      chk("nibble_exchange_op", {1'h1, 5'h09, 1'h0, 8'h5a}, {fw, fa, zw, fd});
      chk("swapfw", 15'h00c3, {7'h00, w});
   end endtask
   task t_dir; begin
      run(3'h2, 5'h0e, 0, 8'h00, 8'h00);
      chk("dirbad", {6'h00, 1'h1, 8'hff}, {6'h00, bd, da});
      chk("dirbadb", {7'h00, 8'hff}, {7'h00, db});
      run(3'h2, 5'h06, 0, 8'h00, 8'h00);
      chk("dir", {7'h00, 8'hc3}, {6'h00, zw, da});
      chk("dirkeep", {7'h00, 8'hff}, {6'h00, bd, db});
      run(3'h2, 5'h07, 0, 8'h00, 8'h00);
      chk("dirb", {7'h00, 8'hc3}, {6'h00, zw, db});
   end endtask
   task t_xor; begin
      run(3'h3, 5'h1f, 0, 8'hc3, 8'h00);
      chk("xorw", {4'h0, 3'h6, 8'h00}, {4'h0, zw, z, fw, w});
      run(3'h3, 5'h05, 1, 8'h0f, 8'h00);
      chk("xorf", {1'h1, 5'h05, 1'h0, 8'h0f}, {fw, fa, z, fd});
      run(3'h4, 5'h00, 1, 8'h00, 8'hff);
      chk("xork", {4'h0, 3'h4, 8'hff}, {4'h0, zw, z, fw, w});
      run(3'h4, 5'h00, 0, 8'h00, 8'hff);
      chk("xork0", {4'h0, 3'h6, 8'h00}, {4'h0, zw, z, fw, w});
   end endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      chk("rst", {7'h00, 8'hff}, {7'h00, da});
      chk("rstw", 15'h0000, {7'h00, w});
      t_zin;
      t_swap;
      t_dir;
      t_xor;
      end_sim;
   end
   initial begin
      #2000 n_errors = n_errors + 1;
      end_sim;
   end
endmodule
